// *** verilog/safe_monitor_pkg.sv ***
// How it works
// - acceptance start suspends internal speed limiting for set time, then restores it
// - acceptance time resets to 40000 ms, writes above 100 s clamp
// - speed monitoring runs straight from reset with no register write, as the extended enable bit resets to 1
// - with motor on, absolute speed is compared with the speed limit, default 20 rpm
// - below-limit flag is high when absolute speed is under the limit, else low
// - hysteresis/filter bit: 1 enables both, 0 gives a plain threshold
// - hysteresis band, default 10 rpm, keeps the flag from chattering
// - filter smooths the speed before comparison, filter setting defaults to 0
// - extended enable bit gates every monitoring function
// - speed off-behaviour 1 drops monitoring at motor off, 0 keeps it
// - kept speed monitoring at motor off freezes flag and asserts safe torque off
// - selected direction monitoring clamps the inhibited-direction setpoint to zero
// - direction checking starts after a delay, default 100 ms
// - during that delay the quick-stop ramp is requested
// - inhibited-direction speed integrates to angle, tolerance default 12 degrees
// - direction enable bit: 1 enables, 0 inhibits direction monitoring
// - direction off-behaviour 1 drops monitoring at motor off, 0 keeps it
// - kept direction monitoring at motor off freezes flags and asserts safe torque off
// - tolerance breach runs stop A (code 0) or stop B (code 1), default 1
// - separate positive-active and negative-active flags
//
// Purpose: constants and types of the safe speed / direction monitor
// Assumes: 10 MHz clock, byte addresses on AXI4-Lite
// Notes:   times counted in 1 ms ticks
package safe_monitor_pkg;
	localparam int CLK_HZ        = 10_000_000;
	localparam int MS_PER_S      = 1000;
	localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
	localparam int ADDR_W        = 8;

	localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_LIMIT    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_HYST     = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_FILTER   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_ACCEPT   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_DELAY    = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_TOL      = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_FSPEED   = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_ANGLE    = 8'h24;

	// control bit positions
	localparam int B_EXT_EN    = 0;
	localparam int B_HYST_EN   = 1;
	localparam int B_DIR_EN    = 2;
	localparam int B_SPD_OFF   = 3;
	localparam int B_DIR_OFF   = 4;
	localparam int B_STOP_RESP = 5;
	localparam int B_SEL_POS   = 6;
	localparam int B_SEL_NEG   = 7;
	localparam int B_ACC_START = 8;

	localparam logic [7:0]  CTRL_RST      = 8'h21;
	localparam logic [15:0] LIMIT_RST     = 16'h0014;
	localparam logic [15:0] HYST_RST      = 16'h000A;
	localparam logic [3:0]  FILTER_RST    = 4'h0;
	localparam logic [16:0] ACCEPT_RST    = 17'h09C40;
	localparam logic [16:0] ACCEPT_MAX_MS = 17'h186A0;
	localparam logic [15:0] DELAY_RST     = 16'h0064;
	localparam logic [15:0] TOL_RST       = 16'h000C;

	// 1 rpm for 1 ms = 6 millidegrees
	localparam logic [31:0] MDEG_PER_RPM_MS = 32'h0000_0006;
	localparam logic [31:0] MDEG_PER_DEG    = 32'h0000_03E8;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {DIR_IDLE, DIR_DELAY, DIR_MONITOR, DIR_FAULT} dir_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} axil_rsp_t;

	typedef struct packed {
		logic        below_limit;
		logic        pos_active;
		logic        neg_active;
		logic        safe_torque_off;
		logic        quick_stop;
		logic        stop_a;
		logic        stop_b;
		logic        limit_active;
		logic        accept_active;
		logic signed [15:0] setpoint;
	} drive_out_t;
endpackage

// *** verilog/safe_speed_direction_monitor.sv ***
// Purpose: safe speed and safe direction monitor with AXI4-Lite registers
// Assumes: speed and setpoint come from logic on clk, signed rpm
// Notes:   all outputs registered, one state struct
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module safe_speed_direction_monitor #(
	parameter int MS_CYCLES = safe_monitor_pkg::MS_CYCLES_DEF
) (
	input  wire logic                       clk,        // 10 MHz
	input  wire logic                       rst_n,      // sync reset
	input  wire safe_monitor_pkg::axil_req_t bus_req,   // axi4-lite request
	output var  safe_monitor_pkg::axil_rsp_t bus_rsp,   // axi4-lite response
	input  wire logic                       motor_on,   // pulses enabled
	input  wire logic signed [15:0]         speed,      // load speed, rpm
	input  wire logic signed [15:0]         setpoint_in, // drive setpoint
	output var  safe_monitor_pkg::drive_out_t drive_out // to setpoint and stop path
);
	import safe_monitor_pkg::*;

	typedef struct packed {
		axil_rsp_t          rsp;
		logic               aw_hold;
		logic [ADDR_W-1:0]  aw_addr;
		logic               w_hold;
		logic [31:0]        w_data;
		logic [3:0]         w_strb;
		logic [7:0]         ctrl;
		logic [15:0]        limit;
		logic [15:0]        hyst;
		logic [3:0]         filt_shift;
		logic [16:0]        accept_time;
		logic [15:0]        dir_delay;
		logic [15:0]        dir_tol;
		logic [31:0]        ms_cnt;
		logic               ms_tick;
		logic [16:0]        accept_ms;
		logic               accept_expired;
		logic [15:0]        filt_speed;
		dir_state_t         dir_state;
		logic [15:0]        delay_ms;
		logic [31:0]        angle;
		drive_out_t         dout;
	} st_t;

	st_t s;
	st_t next_s;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [15:0]        abs_spd;
		logic signed [16:0] diff;
		logic [15:0]        cmp_spd;
		logic [15:0]        low_thr;
		logic               spd_on;
		logic               dir_sel;
		logic               dir_on;
		logic               dir_frozen;
		logic               inhibit_neg;
		logic [31:0]        wv;
		logic [31:0]        rv;
		logic               rd_ok;
		logic               wr_ok;
		logic [31:0]        tol_mdeg;
		logic [31:0]        step;
		logic               moving_bad;
		logic               acc_start;
		logic               spd_frozen;
		abs_spd     = 16'h0000;
		diff        = 17'h00000;
		cmp_spd     = 16'h0000;
		low_thr     = 16'h0000;
		spd_on      = 1'b0;
		dir_sel     = 1'b0;
		dir_on      = 1'b0;
		dir_frozen  = 1'b0;
		inhibit_neg = 1'b0;
		wv          = 32'h0000_0000;
		rv          = 32'h0000_0000;
		rd_ok       = 1'b1;
		wr_ok       = 1'b1;
		tol_mdeg    = 32'h0000_0000;
		step        = 32'h0000_0000;
		moving_bad  = 1'b0;
		acc_start   = 1'b0;
		spd_frozen  = 1'b0;
		next_s      = s;

		// millisecond time base
		next_s.ms_tick = 1'b0;
		if (s.ms_cnt >= 32'(MS_CYCLES - 1)) begin
			next_s.ms_cnt  = 32'h0000_0000;
			next_s.ms_tick = 1'b1;
		end else begin
			next_s.ms_cnt = s.ms_cnt + 32'h0000_0001;
		end

		//////////////////////////////////////////////////////////////////////////
		// bus write: address and data taken in either order
		if (s.rsp.awready && bus_req.awvalid) begin
			next_s.aw_hold     = 1'b1;
			next_s.aw_addr     = bus_req.awaddr;
			next_s.rsp.awready = 1'b0;
		end
		if (s.rsp.wready && bus_req.wvalid) begin
			next_s.w_hold     = 1'b1;
			next_s.w_data     = bus_req.wdata;
			next_s.w_strb     = bus_req.wstrb;
			next_s.rsp.wready = 1'b0;
		end
		if (s.rsp.bvalid && bus_req.bready) begin
			next_s.rsp.bvalid  = 1'b0;
			next_s.rsp.awready = 1'b1;
			next_s.rsp.wready  = 1'b1;
		end
		if (s.aw_hold && s.w_hold && !s.rsp.bvalid) begin
			next_s.aw_hold = 1'b0;
			next_s.w_hold  = 1'b0;
			case (s.aw_addr)
				OFS_CTRL: begin
					wv = merge({23'h000000, 1'b0, s.ctrl}, s.w_data, s.w_strb);
					next_s.ctrl = wv[7:0];
					if (wv[B_ACC_START]) begin
						acc_start             = 1'b1;
						next_s.accept_ms      = 17'h00000;
						next_s.accept_expired = 1'b0;
						next_s.dout.accept_active = 1'b1;
					end
				end
				OFS_LIMIT: begin
					wv = merge({16'h0000, s.limit}, s.w_data, s.w_strb);
					next_s.limit = wv[15:0];
				end
				OFS_HYST: begin
					wv = merge({16'h0000, s.hyst}, s.w_data, s.w_strb);
					next_s.hyst = wv[15:0];
				end
				OFS_FILTER: begin
					wv = merge({28'h0000000, s.filt_shift}, s.w_data, s.w_strb);
					next_s.filt_shift = wv[3:0];
				end
				OFS_ACCEPT: begin
					wv = merge({15'h0000, s.accept_time}, s.w_data, s.w_strb);
					if (wv > {15'h0000, ACCEPT_MAX_MS}) begin
						next_s.accept_time = ACCEPT_MAX_MS;
					end else begin
						next_s.accept_time = wv[16:0];
					end
				end
				OFS_DELAY: begin
					wv = merge({16'h0000, s.dir_delay}, s.w_data, s.w_strb);
					next_s.dir_delay = wv[15:0];
				end
				OFS_TOL: begin
					wv = merge({16'h0000, s.dir_tol}, s.w_data, s.w_strb);
					next_s.dir_tol = wv[15:0];
				end
				default: begin
					wr_ok = 1'b0; // unmapped: nothing stored, error answered
				end
			endcase
			next_s.rsp.bvalid = 1'b1;
			if (wr_ok) begin
				next_s.rsp.bresp = RESP_OKAY;
			end else begin
				next_s.rsp.bresp = RESP_SLVERR;
			end
		end

		//////////////////////////////////////////////////////////////////////////
		// bus read: one cycle to rvalid
		if (s.rsp.rvalid && bus_req.rready) begin
			next_s.rsp.rvalid  = 1'b0;
			next_s.rsp.arready = 1'b1;
		end
		if (s.rsp.arready && bus_req.arvalid) begin
			case (bus_req.araddr)
				OFS_CTRL:   rv = {24'h000000, s.ctrl};
				OFS_LIMIT:  rv = {16'h0000, s.limit};
				OFS_HYST:   rv = {16'h0000, s.hyst};
				OFS_FILTER: rv = {28'h0000000, s.filt_shift};
				OFS_ACCEPT: rv = {15'h0000, s.accept_time};
				OFS_DELAY:  rv = {16'h0000, s.dir_delay};
				OFS_TOL:    rv = {16'h0000, s.dir_tol};
				OFS_STATUS: rv = {20'h00000, s.accept_expired, s.dout.accept_active,
					s.dir_state, s.dout.stop_b, s.dout.stop_a, s.dout.quick_stop,
					s.dout.safe_torque_off, s.dout.neg_active, s.dout.pos_active,
					s.dout.limit_active, s.dout.below_limit};
				OFS_FSPEED: rv = {16'h0000, s.filt_speed};
				OFS_ANGLE:  rv = s.angle;
				default: begin
					rd_ok = 1'b0; // unmapped: data reads zero
				end
			endcase
			next_s.rsp.arready = 1'b0;
			next_s.rsp.rvalid  = 1'b1;
			next_s.rsp.rdata   = rv;
			if (rd_ok) begin
				next_s.rsp.rresp = RESP_OKAY;
			end else begin
				next_s.rsp.rresp = RESP_SLVERR;
			end
		end

		//////////////////////////////////////////////////////////////////////////
		// acceptance timer
		// a restart in the expiry cycle keeps the new run; expired still sets
		if (s.dout.accept_active && s.ms_tick) begin
			if (s.accept_ms + 17'h00001 >= s.accept_time) begin
				next_s.accept_expired = 1'b1;
				if (!acc_start) begin
					next_s.dout.accept_active = 1'b0;
				end
			end else if (!acc_start) begin
				next_s.accept_ms = s.accept_ms + 17'h00001;
			end
		end
		next_s.dout.limit_active = !next_s.dout.accept_active;

		//////////////////////////////////////////////////////////////////////////
		// speed monitoring
		if (speed == 16'sh8000) begin
			abs_spd = 16'h7FFF; // most negative code saturates
		end else if (speed[15]) begin
			abs_spd = 16'(-speed);
		end else begin
			abs_spd = 16'(speed);
		end
		diff = 17'(signed'({1'b0, abs_spd})) - 17'(signed'({1'b0, s.filt_speed}));
		if (s.ms_tick) begin
			next_s.filt_speed = 16'(17'(signed'({1'b0, s.filt_speed})) +
				(diff >>> s.filt_shift));
		end
		if (!s.ctrl[B_HYST_EN] || s.filt_shift == FILTER_RST) begin
			next_s.filt_speed = abs_spd;
		end
		if (s.ctrl[B_HYST_EN]) begin
			cmp_spd = s.filt_speed;
		end else begin
			cmp_spd = abs_spd;
		end
		if (s.hyst >= s.limit) begin
			low_thr = 16'h0000;
		end else begin
			low_thr = s.limit - s.hyst;
		end
		spd_on  = s.ctrl[B_EXT_EN];
		if (!spd_on) begin
			next_s.dout.below_limit = 1'b0;
		end else if (motor_on) begin
			if (!s.ctrl[B_HYST_EN]) begin
				next_s.dout.below_limit = (cmp_spd < s.limit);
			end else if (s.dout.below_limit) begin
				next_s.dout.below_limit = (cmp_spd < s.limit);
			end else begin
				next_s.dout.below_limit = (cmp_spd < low_thr);
			end
		end else if (s.ctrl[B_SPD_OFF]) begin
			next_s.dout.below_limit = 1'b0;
		end
		// frozen otherwise at motor off

		//////////////////////////////////////////////////////////////////////////
		// direction monitoring
		dir_sel = s.ctrl[B_EXT_EN] && s.ctrl[B_DIR_EN] &&
			(s.ctrl[B_SEL_POS] || s.ctrl[B_SEL_NEG]);
		dir_on = dir_sel && (motor_on || !s.ctrl[B_DIR_OFF]);
		dir_frozen = dir_on && !motor_on;
		// both selects set: positive selection wins
		inhibit_neg = s.ctrl[B_SEL_POS];
		tol_mdeg = 32'(s.dir_tol) * MDEG_PER_DEG;
		step = 32'(abs_spd) * MDEG_PER_RPM_MS;
		moving_bad = inhibit_neg ? speed[15] : (speed > 16'sh0000);
		next_s.dout.quick_stop = 1'b0;
		if (!dir_on) begin
			next_s.dir_state       = DIR_IDLE;
			next_s.angle           = 32'h0000_0000;
			next_s.dout.pos_active = 1'b0;
			next_s.dout.neg_active = 1'b0;
			next_s.dout.stop_a     = 1'b0;
			next_s.dout.stop_b     = 1'b0;
		end else if (!dir_frozen) begin
			next_s.dout.pos_active = inhibit_neg;
			next_s.dout.neg_active = !inhibit_neg;
			case (s.dir_state)
				DIR_IDLE: begin
					next_s.dir_state = DIR_DELAY;
					next_s.delay_ms  = 16'h0000;
					next_s.angle     = 32'h0000_0000;
				end
				DIR_DELAY: begin
					next_s.dout.quick_stop = 1'b1;
					if (s.ms_tick) begin
						if (s.delay_ms + 16'h0001 >= s.dir_delay) begin
							next_s.dir_state = DIR_MONITOR;
						end else begin
							next_s.delay_ms = s.delay_ms + 16'h0001;
						end
					end
				end
				DIR_MONITOR: begin
					if (s.ms_tick && moving_bad) begin
						next_s.angle = s.angle + step;
					end
					if (s.angle > tol_mdeg) begin
						next_s.dir_state = DIR_FAULT;
						next_s.dout.stop_a = !s.ctrl[B_STOP_RESP];
						next_s.dout.stop_b = s.ctrl[B_STOP_RESP];
					end
				end
				DIR_FAULT: begin
					next_s.dout.quick_stop = s.dout.stop_b;
				end
				default: next_s.dir_state = DIR_IDLE;
			endcase
		end

		// stop b brakes on the quick-stop ramp from its first cycle, frozen too
		if (next_s.dout.stop_b) begin
			next_s.dout.quick_stop = 1'b1;
		end

		// setpoint clamp for the inhibited direction
		next_s.dout.setpoint = setpoint_in;
		if (dir_on) begin
			if (inhibit_neg && setpoint_in[15]) begin
				next_s.dout.setpoint = 16'sh0000;
			end else if (!inhibit_neg && setpoint_in > 16'sh0000) begin
				next_s.dout.setpoint = 16'sh0000;
			end
		end

		spd_frozen = spd_on && !motor_on && !s.ctrl[B_SPD_OFF];
		next_s.dout.safe_torque_off = next_s.dout.stop_a || next_s.dir_state == DIR_FAULT ||
			spd_frozen || dir_frozen;
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s             <= '0;
			s.rsp.awready <= 1'b1;
			s.rsp.wready  <= 1'b1;
			s.rsp.arready <= 1'b1;
			s.ctrl        <= CTRL_RST;
			s.limit       <= LIMIT_RST;
			s.hyst        <= HYST_RST;
			s.filt_shift  <= FILTER_RST;
			s.accept_time <= ACCEPT_RST;
			s.dir_delay   <= DELAY_RST;
			s.dir_tol     <= TOL_RST;
			s.dir_state   <= DIR_IDLE;
			s.dout.limit_active <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign bus_rsp   = s.rsp;
	assign drive_out = s.dout;
endmodule
`default_nettype wire

// *** testbench/sdm_monitor.sv ***
// Purpose: port checker for the safe speed / direction monitor
// Assumes: one clock, synchronous active-low reset
// Notes:   bound onto the design top
`timescale 1ns/1ps
`default_nettype none
module sdm_chk #(
	parameter int MS_CYCLES = 10
) (
	input wire logic                         clk,         // clock
	input wire logic                         rst_n,       // reset
	input wire safe_monitor_pkg::axil_req_t  bus_req,     // bus request
	input wire safe_monitor_pkg::axil_rsp_t  bus_rsp,     // bus response
	input wire logic                         motor_on,    // pulses on
	input wire logic signed [15:0]           speed,       // load speed
	input wire logic signed [15:0]           setpoint_in, // setpoint in
	input wire safe_monitor_pkg::drive_out_t drive_out    // monitor outputs
);
	import safe_monitor_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_accept_limit: assert property (drive_out.accept_active |-> !drive_out.limit_active)
		else $error("limiting on during acceptance");
	a_stop_single: assert property (!(drive_out.stop_a && drive_out.stop_b))
		else $error("both stop responses");
	a_stopa_torque: assert property (drive_out.stop_a |-> drive_out.safe_torque_off)
		else $error("stop a without torque off");
	a_stopb_ramp: assert property (drive_out.stop_b |-> drive_out.quick_stop)
		else $error("stop b without quick stop");
	a_dir_single: assert property (!(drive_out.pos_active && drive_out.neg_active))
		else $error("both directions active");
	a_clamp_neg: assert property (drive_out.pos_active && $past(drive_out.pos_active)
		&& $past(setpoint_in) < 16'sh0000 |-> drive_out.setpoint == 16'sh0000)
		else $error("negative setpoint passed");
	a_clamp_pos: assert property (drive_out.neg_active && $past(drive_out.neg_active)
		&& $past(setpoint_in) > 16'sh0000 |-> drive_out.setpoint == 16'sh0000)
		else $error("positive setpoint passed");
	a_read_answer: assert property (bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid)
		else $error("read answer late");
	c_stop_a: cover property (drive_out.stop_a);
	c_stop_b: cover property (drive_out.stop_b);
	c_accept: cover property (drive_out.accept_active);
endmodule
bind safe_speed_direction_monitor sdm_chk #(.MS_CYCLES(MS_CYCLES)) u_sdm_chk (.clk(clk),
	.rst_n(rst_n), .bus_req(bus_req), .bus_rsp(bus_rsp), .motor_on(motor_on),
	.speed(speed), .setpoint_in(setpoint_in), .drive_out(drive_out));
`default_nettype wire

// *** testbench/motor_model.sv ***
// Purpose: motor and setpoint source facing the monitor
// Assumes: speed follows the command unless stopped
// Notes:   quick stop ramps 1 rpm per clock, torque off stops dead
`timescale 1ns/1ps
`default_nettype none
module motor_model (
	input  wire logic                         clk,        // clock
	input  wire logic                         rst_n,      // reset
	input  wire safe_monitor_pkg::drive_out_t drive_out,  // monitor outputs
	input  wire logic signed [15:0]           target,     // commanded speed
	output var  logic signed [15:0]           speed,      // measured speed
	output var  logic signed [15:0]           setpoint_in // drive setpoint
);
	import safe_monitor_pkg::*;
	always_ff @(posedge clk) begin
		setpoint_in <= target;
		if (!rst_n || drive_out.safe_torque_off)
			speed <= 16'sh0000;
		else if (!drive_out.quick_stop)
			speed <= target;
		else if (speed > 16'sh0000)
			speed <= speed - 16'sh0001;
		else if (speed < 16'sh0000)
			speed <= speed + 16'sh0001;
	end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench for the safe speed / direction monitor
// Assumes: 1 ms tick shortened to 10 clocks
// Notes:   registers reached through bus tasks
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module tb_top;
	import safe_monitor_pkg::*;
	logic               clk;
	logic               rst_n;
	logic               motor_on;
	logic signed [15:0] target;
	logic signed [15:0] speed;
	logic signed [15:0] setpoint_in;
	axil_req_t          req;
	axil_rsp_t          rsp;
	drive_out_t         o;
	logic [31:0]        rd;
	logic [1:0]         rs;
	int                 error_cnt;
	int                 n_checks;
	logic [7:0]         ra [7] = '{OFS_CTRL, OFS_LIMIT, OFS_HYST, OFS_FILTER, OFS_ACCEPT,
		OFS_DELAY, OFS_TOL};
	logic [31:0]        rv [7] = '{32'h21, 32'h14, 32'hA, 32'h0, 32'h9C40, 32'h64, 32'hC};
	logic signed [15:0] sv [11] = '{16'sh13, 16'shFFED, 16'sh14, 16'shFFEC, 16'sh0,
		16'shFFE7, 16'shF, 16'sh9, 16'shF, 16'sh13, 16'sh14};
	localparam logic [10:0] FV = 11'h393;
	safe_speed_direction_monitor #(.MS_CYCLES(10)) u_safe_speed_direction_monitor (
		.clk(clk), .rst_n(rst_n), .bus_req(req), .bus_rsp(rsp), .motor_on(motor_on),
		.speed(speed), .setpoint_in(setpoint_in), .drive_out(o));
	motor_model u_motor_model (.clk(clk), .rst_n(rst_n), .drive_out(o), .target(target),
		.speed(speed), .setpoint_in(setpoint_in));
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic hang(input bit bad);
		if (bad) begin
			error_cnt++;
			$display("[FAIL] handshake expected 1 seen 0");
			end_sim();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req.awaddr <= a;
		req.wdata <= d;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1 && n < 60);
		req.bready <= 1'b0;
		hang(n >= 60);
	endtask
	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1 && n < 60);
		rd = rsp.rdata;
		rs = rsp.rresp;
		req.rready <= 1'b0;
		hang(n >= 60);
	endtask
	// poll status until the masked bits match
	task automatic wt(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			rdr(OFS_STATUS);
			n++;
		end while ((rd & m) !== v && n < 60);
		hang(n >= 60);
	endtask
	task automatic sp(input logic signed [15:0] v);
		@(posedge clk);
		target <= v;
		repeat (4) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		hang(1'b1);
	end
	initial begin
		rst_n = 1'b0;
		motor_on = 1'b0;
		target = 16'sh0000;
		req = '0;
		req.wstrb = 4'hF;
		error_cnt = 0;
		n_checks = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		motor_on <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rdr(ra[i]);
			`CHK("reset value", rv[i], rd)
		end
		rdr(8'h28);
		`CHK("unmapped resp", RESP_SLVERR, rs)
		$display("test registers done");
		for (int i = 0; i < 11; i++) begin
			if (i == 6)
				wr(OFS_CTRL, 32'h23);
			sp(sv[i]);
			`CHK("below limit", FV[i], o.below_limit)
		end
		wr(OFS_FILTER, 32'h1);
		sp(16'sh003C);
		repeat (10) @(posedge clk);
		rdr(OFS_FSPEED);
		`CHK("filter lag", 1'b1, rd > 32'h14 && rd < 32'h3C)
		wr(OFS_CTRL, 32'h20);
		sp(16'sh0000);
		`CHK("gated flag", 1'b0, o.below_limit)
		wr(OFS_CTRL, 32'h21);
		sp(16'sh001E);
		motor_on <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK("frozen flag", 1'b0, o.below_limit)
		`CHK("torque off", 1'b1, o.safe_torque_off)
		wr(OFS_CTRL, 32'h29);
		repeat (2) @(posedge clk);
		`CHK("speed released", 2'b00, {o.below_limit, o.safe_torque_off})
		motor_on <= 1'b1;
		sp(16'sh0000);
		$display("test speed done");
		wr(OFS_ACCEPT, 32'h30D40);
		rdr(OFS_ACCEPT);
		`CHK("accept clamp", 32'h186A0, rd)
		wr(OFS_ACCEPT, 32'h3);
		wr(OFS_CTRL, 32'h121);
		repeat (10) @(posedge clk);
		`CHK("limit off", 2'b01, {o.limit_active, o.accept_active})
		repeat (40) @(posedge clk);
		`CHK("limit back", 2'b10, {o.limit_active, o.accept_active})
		$display("test acceptance done");
		wr(OFS_DELAY, 32'h5);
		wr(OFS_TOL, 32'h1);
		wr(OFS_CTRL, 32'h65);
		sp(16'shFF9C);
		`CHK("clamp", 16'sh0000, o.setpoint)
		`CHK("pos flag", 2'b10, {o.pos_active, o.neg_active})
		`CHK("delay ramp", 1'b1, o.quick_stop)
		sp(16'sh0032);
		`CHK("pass", 16'sh0032, o.setpoint)
		sp(16'sh0000);
		wt(32'h300, 32'h200);
		`CHK("ramp end", 1'b0, o.quick_stop)
		sp(16'shFFCE);
		wt(32'h80, 32'h80);
		`CHK("stop b", 2'b01, {o.stop_a, o.safe_torque_off})
		`CHK("stop b ramp", 1'b1, o.quick_stop)
		sp(16'sh0000);
		wr(OFS_CTRL, 32'h61);
		rdr(OFS_ANGLE);
		`CHK("angle clear", 32'h0, rd)
		`CHK("dir inhibit", 2'b00, {o.pos_active, o.stop_b})
		$display("test stop b done");
		wr(OFS_CTRL, 32'h85);
		wt(32'h300, 32'h200);
		`CHK("neg flag", 2'b01, {o.pos_active, o.neg_active})
		sp(16'sh0032);
		wt(32'h40, 32'h40);
		`CHK("stop a", 2'b11, {o.safe_torque_off, o.stop_a})
		sp(16'sh0000);
		wr(OFS_CTRL, 32'h65);
		motor_on <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK("held dir", 2'b11, {o.pos_active, o.safe_torque_off})
		wr(OFS_CTRL, 32'h75);
		repeat (4) @(posedge clk);
		`CHK("dropped dir", 1'b0, o.pos_active)
		$display("test direction done");
		end_sim();
	end
endmodule
`default_nettype wire
